// ---- dcrsb_pkg.sv ----
// Constants and types for the digital core rate select bank.
// Assumes a single system clock and a simple word-wide register port from the host control logic.
package dcrsb_pkg;

   // =====================================================================
   // Widths and counts
   localparam int unsigned DCRSB_ADDR_W   = 16;
   localparam int unsigned DCRSB_DATA_W   = 16;
   localparam int unsigned DCRSB_SEL_W    = 4;
   localparam int unsigned DCRSB_NUM_SEL  = 14;
   localparam int unsigned DCRSB_NUM_BUSR = 6;

   // =====================================================================
   // Register offsets (word addresses on the host control port)
   localparam logic [15:0] DCRSB_OFS_BUS_RATE_RX6_RX5  = 16'h05e7;
   localparam logic [15:0] DCRSB_OFS_BUS_RATE_RX8_RX7  = 16'h05e8;
   localparam logic [15:0] DCRSB_OFS_BUS_RATE_TX2_TX1  = 16'h05e9;
   localparam logic [15:0] DCRSB_OFS_BUS_RATE_TX4_TX3  = 16'h05ea;
   localparam logic [15:0] DCRSB_OFS_BUS_RATE_TX6_TX5  = 16'h05eb;
   localparam logic [15:0] DCRSB_OFS_BUS_RATE_TX8_TX7  = 16'h05ec;
   localparam logic [15:0] DCRSB_OFS_EFFECTS_GROUP_CTL = 16'h0e00;
   localparam logic [15:0] DCRSB_OFS_DSP_CORE_ONE_CTL  = 16'h1100;

   // =====================================================================
   // Field positions (low bit of each 4-bit selector)
   localparam int unsigned DCRSB_POS_EVEN_CH = 11;
   localparam int unsigned DCRSB_POS_ODD_CH  = 3;
   localparam int unsigned DCRSB_POS_GROUP   = 12;

   // Selector slots: 0..3 rx5..rx8, 4..11 tx1..tx8, 12 effects group, 13 dsp core one
   localparam int unsigned DCRSB_IDX_EFFECTS = 12;
   localparam int unsigned DCRSB_IDX_DSP     = 13;

   // =====================================================================
   // Reset values and rate codes
   localparam logic [3:0]  DCRSB_SEL_RST   = 4'h0;
   localparam logic [15:0] DCRSB_REG_RST   = 16'h0000;
   localparam logic [3:0]  DCRSB_CODE_SYS1 = 4'h0;
   localparam logic [3:0]  DCRSB_CODE_SYS2 = 4'h1;
   localparam logic [3:0]  DCRSB_CODE_SYS3 = 4'h2;
   localparam logic [3:0]  DCRSB_CODE_ASY1 = 4'h8;
   localparam logic [3:0]  DCRSB_CODE_ASY2 = 4'h9;

   // =====================================================================
   // Host register request
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } dcrsb_req_t;

   // Decoded selector: which clock domain, which rate of that domain, code defined
   typedef struct packed {
      logic       valid;
      logic       async_dom;
      logic [1:0] rate_num;
   } dcrsb_dec_t;

endpackage

// ---- dcrsb_top.sv ----
// Rate selector register bank: stores the 4-bit rate codes of bus channels,
// effects group and dsp core one, and drives them out decoded per path.
// Assumes HOST_REQ comes from host control logic on SYS_CLK, one access per cycle.
module dcrsb_top
   import dcrsb_pkg::*;
(
   input  wire logic                                    SYS_CLK,
   input  wire logic                                    RST_N,
   input  wire dcrsb_req_t                              HOST_REQ,
   output logic       [DCRSB_DATA_W-1:0]                RD_DATA,
   output logic                                         RD_ACK,
   output logic       [DCRSB_NUM_SEL-1:0][DCRSB_SEL_W-1:0] RATE_SEL,
   output logic       [DCRSB_NUM_SEL-1:0]               PATH_ASYNC,
   output logic       [DCRSB_NUM_SEL-1:0][1:0]          RATE_NUM,
   output logic       [DCRSB_NUM_SEL-1:0]               CODE_VALID
);

   // =====================================================================
   // Decoding helpers
   function automatic dcrsb_dec_t decode_rate(input logic [3:0] code);
      dcrsb_dec_t d;
      d = '0;
      unique case (code)
         DCRSB_CODE_SYS1: d = '{valid: 1'b1, async_dom: 1'b0, rate_num: 2'h0};
         DCRSB_CODE_SYS2: d = '{valid: 1'b1, async_dom: 1'b0, rate_num: 2'h1};
         DCRSB_CODE_SYS3: d = '{valid: 1'b1, async_dom: 1'b0, rate_num: 2'h2};
         DCRSB_CODE_ASY1: d = '{valid: 1'b1, async_dom: 1'b1, rate_num: 2'h0};
         DCRSB_CODE_ASY2: d = '{valid: 1'b1, async_dom: 1'b1, rate_num: 2'h1};
         // Reserved codes still pick a domain from bit 3 so no path floats
         default:         d = '{valid: 1'b0, async_dom: code[3], rate_num: 2'h0};
      endcase
      return d;
   endfunction

   // Bus register index 0..5, or 7 when not a bus register
   function automatic logic [2:0] bus_index(input logic [15:0] a);
      logic [15:0] k;
      k = a - DCRSB_OFS_BUS_RATE_RX6_RX5;
      if (a >= DCRSB_OFS_BUS_RATE_RX6_RX5 && a <= DCRSB_OFS_BUS_RATE_TX8_TX7) begin
         return k[2:0];
      end
      return 3'h7;
   endfunction

   // =====================================================================
   // Selector storage
   logic [DCRSB_NUM_SEL-1:0][DCRSB_SEL_W-1:0] sel_r;
   logic [DCRSB_NUM_SEL-1:0][DCRSB_SEL_W-1:0] sel_nxt;
   logic [2:0]                                 wr_bidx;
   logic                                       wr_bus;

   assign wr_bidx = bus_index(HOST_REQ.addr);
   assign wr_bus  = HOST_REQ.wr && (wr_bidx != 3'h7);

   always_comb begin
      sel_nxt = sel_r;
      // Values are stored exactly as written; reserved codes are flagged, not corrected
      if (wr_bus) begin
         sel_nxt[{wr_bidx, 1'b0}] = HOST_REQ.wdata[DCRSB_POS_ODD_CH +: DCRSB_SEL_W];
         sel_nxt[{wr_bidx, 1'b1}] = HOST_REQ.wdata[DCRSB_POS_EVEN_CH +: DCRSB_SEL_W];
      end
      if (HOST_REQ.wr && HOST_REQ.addr == DCRSB_OFS_EFFECTS_GROUP_CTL) begin
         sel_nxt[DCRSB_IDX_EFFECTS] = HOST_REQ.wdata[DCRSB_POS_GROUP +: DCRSB_SEL_W];
      end
      if (HOST_REQ.wr && HOST_REQ.addr == DCRSB_OFS_DSP_CORE_ONE_CTL) begin
         sel_nxt[DCRSB_IDX_DSP] = HOST_REQ.wdata[DCRSB_POS_GROUP +: DCRSB_SEL_W];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sel_r <= {DCRSB_NUM_SEL{DCRSB_SEL_RST}};
      end else begin
         sel_r <= sel_nxt;
      end
   end

   // =====================================================================
   // Path outputs, registered from the next selector values so they track sel_r
   logic [DCRSB_NUM_SEL-1:0]      async_nxt;
   logic [DCRSB_NUM_SEL-1:0][1:0] num_nxt;
   logic [DCRSB_NUM_SEL-1:0]      valid_nxt;

   always_comb begin
      dcrsb_dec_t d;
      d = '0;
      for (int i = 0; i < DCRSB_NUM_SEL; i++) begin
         d            = decode_rate(sel_nxt[i]);
         async_nxt[i] = d.async_dom;
         num_nxt[i]   = d.rate_num;
         valid_nxt[i] = d.valid;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RATE_SEL   <= {DCRSB_NUM_SEL{DCRSB_SEL_RST}};
         PATH_ASYNC <= '0;
         RATE_NUM   <= '0;
         CODE_VALID <= '1;
      end else begin
         RATE_SEL   <= sel_nxt;
         PATH_ASYNC <= async_nxt;
         RATE_NUM   <= num_nxt;
         CODE_VALID <= valid_nxt;
      end
   end

   // =====================================================================
   // Read port: data one cycle after the request, unmapped reads as zero
   logic [DCRSB_DATA_W-1:0] rd_nxt;
   logic [2:0]              rd_bidx;

   always_comb begin
      rd_bidx = bus_index(HOST_REQ.addr);
      rd_nxt  = DCRSB_REG_RST;
      if (HOST_REQ.rd) begin
         if (rd_bidx != 3'h7) begin
            rd_nxt[DCRSB_POS_ODD_CH +: DCRSB_SEL_W]  = sel_r[{rd_bidx, 1'b0}];
            rd_nxt[DCRSB_POS_EVEN_CH +: DCRSB_SEL_W] = sel_r[{rd_bidx, 1'b1}];
         end else if (HOST_REQ.addr == DCRSB_OFS_EFFECTS_GROUP_CTL) begin
            rd_nxt[DCRSB_POS_GROUP +: DCRSB_SEL_W] = sel_r[DCRSB_IDX_EFFECTS];
         end else if (HOST_REQ.addr == DCRSB_OFS_DSP_CORE_ONE_CTL) begin
            rd_nxt[DCRSB_POS_GROUP +: DCRSB_SEL_W] = sel_r[DCRSB_IDX_DSP];
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RD_DATA <= DCRSB_REG_RST;
         RD_ACK  <= 1'b0;
      end else begin
         RD_DATA <= rd_nxt;
         RD_ACK  <= HOST_REQ.rd;
      end
   end

   // =====================================================================
   // Checks
   logic boot_r;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         boot_r <= 1'b0;
      end else begin
         boot_r <= 1'b1;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   sequence s_fx_write_async1;
      HOST_REQ.wr && HOST_REQ.addr == DCRSB_OFS_EFFECTS_GROUP_CTL
         && HOST_REQ.wdata[15:12] == DCRSB_CODE_ASY1;
   endsequence

   sequence s_fx_read_quiet;
      HOST_REQ.rd && !HOST_REQ.wr && HOST_REQ.addr == DCRSB_OFS_EFFECTS_GROUP_CTL;
   endsequence

   sequence s_fx_write_sys3;
      HOST_REQ.wr && HOST_REQ.addr == DCRSB_OFS_EFFECTS_GROUP_CTL
         && HOST_REQ.wdata[15:12] == DCRSB_CODE_SYS3;
   endsequence

   AST_RESET_ZERO: assert property (!boot_r |-> RATE_SEL == '0 && RD_DATA == '0)
      else $error("selectors not zero after reset");

   // Decode outputs must sit at their reset values on the first edge after release too
   AST_RESET_OUTS: assert property (!boot_r |-> CODE_VALID == '1 && PATH_ASYNC == '0 && RATE_NUM == '0)
      else $error("path decode outputs not at reset values");

   AST_ODD_FIELD: assert property (wr_bus |=>
      RATE_SEL[$past({wr_bidx, 1'b0})] == $past(HOST_REQ.wdata[6:3]))
      else $error("odd channel field not taken from bits 6:3");

   AST_EVEN_FIELD: assert property (wr_bus |=>
      RATE_SEL[$past({wr_bidx, 1'b1})] == $past(HOST_REQ.wdata[14:11]))
      else $error("even channel field not taken from bits 14:11");

   AST_DSP_FIELD: assert property (HOST_REQ.wr && HOST_REQ.addr == DCRSB_OFS_DSP_CORE_ONE_CTL |=>
      RATE_SEL[13] == $past(HOST_REQ.wdata[15:12]))
      else $error("dsp selector not taken from bits 15:12");

   AST_ASYNC_DECODE: assert property (s_fx_write_async1 |=>
      PATH_ASYNC[12] && CODE_VALID[12] && RATE_NUM[12] == 2'h0)
      else $error("code 1000 not decoded as first second-domain rate");

   AST_SYS_DECODE: assert property (s_fx_write_sys3 |=>
      !PATH_ASYNC[12] && CODE_VALID[12] && RATE_NUM[12] == 2'h2)
      else $error("code 0010 not decoded as third system rate");

   AST_DOMAIN_BIT: assert property (CODE_VALID[3] |-> PATH_ASYNC[3] == RATE_SEL[3][3])
      else $error("path domain disagrees with its code");

   AST_HOLD: assert property (!HOST_REQ.wr |=> $stable(RATE_SEL))
      else $error("selector changed without a write");

   AST_READBACK: assert property (s_fx_read_quiet |=>
      RD_ACK && RD_DATA[11:0] == '0 && RD_DATA[15:12] == RATE_SEL[12])
      else $error("effects register readback wrong");

   AST_READ_ACK: assert property (HOST_REQ.rd |=> RD_ACK)
      else $error("read not acknowledged one cycle later");

   // Idle read port must not leak stale data onto the host side
   AST_IDLE_READ: assert property (!HOST_REQ.rd |=> !RD_ACK && RD_DATA == '0)
      else $error("read port active without a read");

endmodule

// ---- test_digital_core_rate_select_bank.sv ----
// Self-checking bench for the rate selector register bank.
// Assumes dcrsb_pkg and dcrsb_top compiled first; the bench drives HOST_REQ on falling edges.
module test_digital_core_rate_select_bank
   import dcrsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // =====================================================================
   // Signals
   logic                                        sys_clk;
   logic                                        rst_n;
   dcrsb_req_t                                  host_req;
   logic [DCRSB_DATA_W-1:0]                     rd_data;
   logic                                        rd_ack;
   logic [DCRSB_NUM_SEL-1:0][DCRSB_SEL_W-1:0]   rate_sel;
   logic [DCRSB_NUM_SEL-1:0]                    path_async;
   logic [DCRSB_NUM_SEL-1:0][1:0]               rate_num;
   logic [DCRSB_NUM_SEL-1:0]                    code_valid;
   int                                          num_errors;
   int                                          total_checks;
   logic [15:0]                                 bus_ofs [6] = '{DCRSB_OFS_BUS_RATE_RX6_RX5, DCRSB_OFS_BUS_RATE_RX8_RX7,
      DCRSB_OFS_BUS_RATE_TX2_TX1, DCRSB_OFS_BUS_RATE_TX4_TX3, DCRSB_OFS_BUS_RATE_TX6_TX5, DCRSB_OFS_BUS_RATE_TX8_TX7};

   dcrsb_top dut_u (
      .SYS_CLK    (sys_clk),
      .RST_N      (rst_n),
      .HOST_REQ   (host_req),
      .RD_DATA    (rd_data),
      .RD_ACK     (rd_ack),
      .RATE_SEL   (rate_sel),
      .PATH_ASYNC (path_async),
      .RATE_NUM   (rate_num),
      .CODE_VALID (code_valid)
   );

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // =====================================================================
   // Shared tasks
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One strobe cycle; outputs of that access are settled at the return
   task automatic acc(input logic [15:0] a, input logic w, input logic r, input logic [15:0] d);
      @(negedge sys_clk);
      host_req = '{addr: a, wr: w, rd: r, wdata: d};
      @(negedge sys_clk);
      host_req.wr = 1'b0;
      host_req.rd = 1'b0;
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
      acc(a, 1'b0, 1'b1, 16'h0000);
      chk(rd_ack, 1'b1);
      chk(rd_data, exp);
      @(negedge sys_clk);
      chk(rd_ack, 1'b0);
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // =====================================================================
   // Scenarios
   task automatic t_reset_values();
      for (int i = 0; i < 6; i++) rd_chk(bus_ofs[i], 16'h0000);
      rd_chk(DCRSB_OFS_EFFECTS_GROUP_CTL, 16'h0000);
      rd_chk(DCRSB_OFS_DSP_CORE_ONE_CTL, 16'h0000);
      chk(rate_sel, '0);
      chk(code_valid, {DCRSB_NUM_SEL{1'b1}});
      $display("test reset values done");
   endtask

   // Each defined code once; software never writes reserved codes, and the rates
   // behind the codes and the limiter enable live outside this bank
   task automatic t_codes();
      logic [3:0] codes [5];
      logic [3:0] c;
      codes = '{DCRSB_CODE_ASY1, DCRSB_CODE_SYS1, DCRSB_CODE_SYS2, DCRSB_CODE_SYS3, DCRSB_CODE_ASY2};
      for (int k = 0; k < 5; k++) begin
         c = codes[k];
         acc(DCRSB_OFS_EFFECTS_GROUP_CTL, 1'b1, 1'b0, {c, 12'hfff});
         chk(rate_sel[DCRSB_IDX_EFFECTS], c);
         chk(code_valid[DCRSB_IDX_EFFECTS], 1'b1);
         chk(path_async[DCRSB_IDX_EFFECTS], c[3]);
         chk(rate_num[DCRSB_IDX_EFFECTS], c[1:0]);
      end
      $display("test codes done");
   endtask

   // Two different defined codes per bus register and one for dsp core one, with all non-field bits set on write
   task automatic t_fields();
      logic [3:0]  ev;
      logic [3:0]  od;
      logic [15:0] d;
      logic [3:0]  nz [4];
      nz = '{DCRSB_CODE_SYS2, DCRSB_CODE_SYS3, DCRSB_CODE_ASY1, DCRSB_CODE_ASY2};
      for (int i = 0; i < 6; i++) begin
         od = nz[i % 4];
         ev = nz[(i + 1) % 4];
         d  = 16'h8787 | {1'b0, ev, 4'h0, od, 3'h0};
         acc(bus_ofs[i], 1'b1, 1'b0, d);
         chk(rate_sel[2*i], od);
         chk(rate_sel[2*i+1], ev);
         rd_chk(bus_ofs[i], d & 16'h7878);
      end
      acc(DCRSB_OFS_DSP_CORE_ONE_CTL, 1'b1, 1'b0, 16'h9fff);
      chk(rate_sel[DCRSB_IDX_DSP], 4'h9);
      chk(path_async[DCRSB_IDX_DSP], 1'b1);
      chk(rate_num[DCRSB_IDX_DSP], 2'h1);
      rd_chk(DCRSB_OFS_DSP_CORE_ONE_CTL, 16'h9000);
      // Simultaneous write and read returns the value held before
      acc(DCRSB_OFS_EFFECTS_GROUP_CTL, 1'b1, 1'b1, 16'h2000);
      chk(rd_data, 16'h9000);
      chk(rate_sel[DCRSB_IDX_EFFECTS], 4'h2);
      chk(rate_num[DCRSB_IDX_EFFECTS], 2'h2);
      $display("test fields done");
   endtask

   task automatic t_unmapped_and_reset();
      logic [DCRSB_NUM_SEL-1:0][DCRSB_SEL_W-1:0] held;
      held = {4'h9, 4'h2, 4'h8, 4'h2, 4'h2, 4'h1, 4'h1, 4'h9, 4'h9, 4'h8, 4'h8, 4'h2, 4'h2, 4'h1};
      acc(16'h05e6, 1'b1, 1'b0, 16'hcfcf);
      chk(rate_sel, held);
      rd_chk(16'h05e6, 16'h0000);
      @(negedge sys_clk);
      rst_n = 1'b0;
      @(negedge sys_clk);
      chk(rate_sel, '0);
      chk(path_async, '0);
      chk(rate_num, '0);
      rst_n = 1'b1;
      rd_chk(DCRSB_OFS_BUS_RATE_TX8_TX7, 16'h0000);
      $display("test unmapped and reset done");
   endtask

   // =====================================================================
   // Main sequence and watchdog
   initial begin
      num_errors   = 0;
      total_checks = 0;
      rst_n        = 1'b0;
      host_req     = '{addr: 16'h0000, wr: 1'b0, rd: 1'b0, wdata: 16'h0000};
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      t_reset_values();
      t_codes();
      t_fields();
      t_unmapped_and_reset();
      tally_and_finish();
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      tally_and_finish();
   end
endmodule
